// file: verilog/tech_irq_pkg.sv
// Purpose: Shared constants and types of the technology interrupt logic.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Event ids 0..15 are input edges, 16..19 end of measurement.
package tech_irq_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_DIAG_ERROR_SUMMARY  = 4'h0;
  localparam logic [3:0] OFS_DIAG_MODULE_CLASS   = 4'h1;
  localparam logic [3:0] OFS_DIAG_RESERVED_BYTE  = 4'h2;
  localparam logic [3:0] OFS_DIAG_LOST_EVENT     = 4'h3;
  localparam logic [3:0] OFS_EDGE_FLAGS_LOW      = 4'h8;
  localparam logic [3:0] OFS_EDGE_FLAGS_HIGH     = 4'h9;
  localparam logic [3:0] OFS_MEASURE_DONE_CH01   = 4'hA;
  localparam logic [3:0] OFS_MEASURE_DONE_CH23   = 4'hB;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         CHANNEL_ERROR_BIT = 3;
  localparam int         LOST_EVENT_BIT    = 6;
  localparam int         CHAN_INFO_BIT     = 4;
  localparam logic [3:0] CLASS_ANALOG      = 4'h5;
  localparam logic [3:0] CLASS_DIGITAL     = 4'hF;
  localparam logic [7:0] DIAG_BYTE_RESET   = 8'h00;
  localparam logic [7:0] FIX_ZERO_BYTE     = 8'h00;
  localparam logic [31:0] FLAGS_RESET      = 32'h0000_0000;
  localparam int         NUM_EDGES         = 16;
  localparam int         NUM_EVENTS        = 20;
  localparam int         ID_W              = 5;
  localparam int         MEAS_BYTE_BASE    = 16;
  localparam int         MEAS_CH_STRIDE    = 4;

  typedef enum logic [1:0] {
    MODE_NONE     = 2'b00,
    MODE_COUNTING = 2'b01,
    MODE_FREQ     = 2'b10,
    MODE_PWM      = 2'b11
  } tech_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_PROC     = 2'b01,
    ST_DIAG_IN  = 2'b10,
    ST_DIAG_OUT = 2'b11
  } svc_state_e;

endpackage

// file: verilog/event_fifo_if.sv
// Purpose: Push and pop signals of one event queue.
// Assumes: Single clock domain.
// Notes:   Pop data is valid whenever empty is low.
`timescale 1ns/1ps
interface event_fifo_if #(parameter int W = 5);
  logic         push;
  logic [W-1:0] push_data;
  logic         full;
  logic         pop;
  logic [W-1:0] pop_data;
  logic         empty;
  modport producer (output push, output push_data, input full,
                    output pop, input pop_data, input empty);
  modport queue (input push, input push_data, output full,
                 input pop, output pop_data, output empty);
endinterface

// file: verilog/event_fifo.sv
// Purpose: First-in first-out queue of event ids.
// Assumes: Producer may also push while full is high.
// Notes:   A push while full is ignored; the producer counts it lost.
`timescale 1ns/1ps
module event_fifo #(
  parameter int W     = 5,
  parameter int DEPTH = 8
) (
  input wire logic         clock,
  input wire logic         rst,
  event_fifo_if.queue      q
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          do_push;
  logic          do_pop;

  assign do_push     = q.push && !q.full;
  assign do_pop      = q.pop && !q.empty;
  assign q.full      = (count == (AW+1)'(DEPTH));
  assign q.empty     = (count == '0);
  assign q.pop_data  = mem[rd_ptr];

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_ptr] <= q.push_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wrap_inc(wr_ptr);
      end
      if (do_pop) begin
        rd_ptr <= wrap_inc(rd_ptr);
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

endmodule

// file: verilog/tech_irq_diag.sv
// Purpose: Process and diagnostic interrupt logic of the technology block.
// Assumes: Handlers acknowledge with one-cycle done pulses.
// Notes:   Events are one-cycle pulses; one event is taken per cycle.
`timescale 1ns/1ps
module tech_irq_diag #(
  parameter int         PROC_DEPTH  = 8,
  parameter int         DIAG_DEPTH  = 8,
  parameter logic [3:0] MODULE_CLASS = tech_irq_pkg::CLASS_DIGITAL,
  // Arbitrary neutral module address.
  parameter logic [7:0] MODULE_ADDR = 8'h10
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [1:0]  tech_mode,
  input  wire logic        diag_proc_setting,
  input  wire logic        counter_out_en,
  input  wire logic        diag_global_en,
  input  wire logic [15:0] input_edge,
  input  wire logic [3:0]  measure_done,
  input  wire logic        proc_done,
  input  wire logic        diag_done,
  input  wire logic [3:0]  reg_addr,
  output logic             process_irq_handler,
  output logic [31:0]      proc_flags,
  output logic             diag_irq_handler,
  output logic             diag_outgoing,
  output logic [31:0]      diag_record,
  output logic             system_fault_indicator,
  output logic             log_strobe,
  output logic [15:0]      log_entry,
  output logic [7:0]       reg_rdata
);

  localparam int NE = tech_irq_pkg::NUM_EVENTS;
  localparam int IW = tech_irq_pkg::ID_W;

  // ----------------------------------------------------------------
  // Enables
  // ----------------------------------------------------------------
  logic tech_sel;
  logic proc_en;
  logic diag_en;

  assign tech_sel = (tech_mode != tech_irq_pkg::MODE_NONE);
  assign proc_en  = tech_sel && diag_proc_setting && counter_out_en &&
                    (tech_mode != tech_irq_pkg::MODE_PWM);
  assign diag_en  = tech_sel && diag_proc_setting && diag_global_en;

  // ----------------------------------------------------------------
  // Event intake
  // ----------------------------------------------------------------
  logic [NE-1:0] pending;
  logic [NE-1:0] raw_events;
  logic [NE-1:0] diag_chan;
  logic [NE-1:0] queued;
  logic          ev_valid;
  logic [IW-1:0] ev_id;

  // Edges count in counting and frequency modes; measurement ends only
  // exist in frequency mode.
  assign raw_events = {
    (tech_mode == tech_irq_pkg::MODE_FREQ) ? measure_done : 4'h0,
    (tech_mode == tech_irq_pkg::MODE_COUNTING ||
     tech_mode == tech_irq_pkg::MODE_FREQ) ? input_edge : 16'h0000};

  always_comb begin
    ev_valid = 1'b0;
    ev_id    = '0;
    for (int i = NE - 1; i >= 0; i--) begin
      if (pending[i]) begin
        ev_valid = 1'b1;
        ev_id    = IW'(i);
      end
    end
  end

  // A new pulse on the event being taken keeps it pending: set wins.
  always_ff @(posedge clock) begin
    if (rst) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~(NE'(ev_valid) << ev_id)) | raw_events;
    end
  end

  // ----------------------------------------------------------------
  // Queues
  // ----------------------------------------------------------------
  event_fifo_if #(.W(IW)) proc_q ();
  event_fifo_if #(.W(IW)) diag_q ();

  event_fifo #(.W(IW), .DEPTH(PROC_DEPTH)) proc_fifo (
    .clock (clock),
    .rst   (rst),
    .q     (proc_q)
  );

  event_fifo #(.W(IW), .DEPTH(DIAG_DEPTH)) diag_fifo (
    .clock (clock),
    .rst   (rst),
    .q     (diag_q)
  );

  typedef tech_irq_pkg::svc_state_e svc_state_e;

  svc_state_e    state;
  logic [IW-1:0] cur_id;
  logic          susp_valid;
  logic [IW-1:0] susp_id;
  logic          ev_live;
  logic          ev_recur;
  logic          ev_to_diag;
  logic          ev_to_proc;
  logic          enter_in;
  logic          enter_out;
  logic          lost_event;
  logic          out_done;
  logic          silent_out;

  assign ev_live    = ev_valid && proc_en && !diag_chan[ev_id];
  assign ev_recur   = ev_live && state == tech_irq_pkg::ST_PROC &&
                      cur_id == ev_id;
  assign ev_to_diag = ev_live && !ev_recur && queued[ev_id];
  assign ev_to_proc = ev_live && !ev_recur && !queued[ev_id];

  assign proc_q.push      = ev_to_proc;
  assign proc_q.push_data = ev_id;
  assign diag_q.push      = ev_to_diag && diag_en;
  assign diag_q.push_data = ev_id;

  // Dispatch order from idle: diagnostics, then the interrupted process,
  // then queued processes.
  assign diag_q.pop = state == tech_irq_pkg::ST_IDLE && !diag_q.empty;
  assign proc_q.pop = state == tech_irq_pkg::ST_IDLE && diag_q.empty &&
                      !susp_valid && !proc_q.empty;

  assign enter_in   = (ev_recur && diag_en) || diag_q.pop;
  assign out_done   = state == tech_irq_pkg::ST_PROC && proc_done &&
                      diag_chan[cur_id];
  assign enter_out  = out_done && diag_en;
  assign silent_out = out_done && !diag_en;
  assign lost_event = (ev_recur && !diag_en) ||
                      (ev_to_proc && proc_q.full) ||
                      (ev_to_diag && (!diag_en || diag_q.full));

  // ----------------------------------------------------------------
  // Service sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state      <= tech_irq_pkg::ST_IDLE;
      cur_id     <= '0;
      susp_valid <= 1'b0;
      susp_id    <= '0;
    end else begin
      case (state)
        tech_irq_pkg::ST_IDLE: begin
          if (diag_q.pop) begin
            state  <= tech_irq_pkg::ST_DIAG_IN;
            cur_id <= diag_q.pop_data;
          end else if (susp_valid) begin
            state      <= tech_irq_pkg::ST_PROC;
            cur_id     <= susp_id;
            susp_valid <= 1'b0;
          end else if (proc_q.pop) begin
            state  <= tech_irq_pkg::ST_PROC;
            cur_id <= proc_q.pop_data;
          end
        end
        tech_irq_pkg::ST_PROC: begin
          if (ev_recur && diag_en) begin
            state      <= tech_irq_pkg::ST_DIAG_IN;
            susp_valid <= 1'b1;
            susp_id    <= cur_id;
          end else if (enter_out) begin
            state <= tech_irq_pkg::ST_DIAG_OUT;
          end else if (proc_done) begin
            state <= tech_irq_pkg::ST_IDLE;
          end
        end
        tech_irq_pkg::ST_DIAG_IN,
        tech_irq_pkg::ST_DIAG_OUT: begin
          if (diag_done) begin
            state <= tech_irq_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= tech_irq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Channels under diagnosis; a channel leaves when its outgoing message
  // is done, or at once when no outgoing message may be sent.
  always_ff @(posedge clock) begin
    if (rst) begin
      diag_chan <= '0;
    end else begin
      for (int i = 0; i < NE; i++) begin
        if ((ev_recur && diag_en && ev_id == IW'(i)) ||
            (diag_q.push && !diag_q.full && ev_id == IW'(i))) begin
          diag_chan[i] <= 1'b1;
        end else if ((silent_out && cur_id == IW'(i)) ||
                     (state == tech_irq_pkg::ST_DIAG_OUT && diag_done &&
                      cur_id == IW'(i))) begin
          diag_chan[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      queued <= '0;
    end else begin
      for (int i = 0; i < NE; i++) begin
        if (proc_q.push && !proc_q.full && ev_id == IW'(i)) begin
          queued[i] <= 1'b1;
        end else if (proc_q.pop && proc_q.pop_data == IW'(i)) begin
          queued[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Process handler outputs
  // ----------------------------------------------------------------
  function automatic logic [31:0] flag_of(input logic [IW-1:0] id);
    logic [31:0] f;
    f = '0;
    if (id < IW'(tech_irq_pkg::NUM_EDGES)) begin
      f[id] = 1'b1;
    end else begin
      f[tech_irq_pkg::MEAS_BYTE_BASE +
        tech_irq_pkg::MEAS_CH_STRIDE * int'(id - IW'(16))] = 1'b1;
    end
    flag_of = f;
  endfunction

  always_ff @(posedge clock) begin
    if (rst) begin
      process_irq_handler <= 1'b0;
      proc_flags          <= tech_irq_pkg::FLAGS_RESET;
    end else if (state == tech_irq_pkg::ST_IDLE && !diag_q.pop &&
                 (susp_valid || proc_q.pop)) begin
      process_irq_handler <= 1'b1;
      proc_flags <= flag_of(susp_valid ? susp_id : proc_q.pop_data);
    end else if (state == tech_irq_pkg::ST_PROC &&
                 ((ev_recur && diag_en) || proc_done)) begin
      process_irq_handler <= 1'b0;
      proc_flags          <= tech_irq_pkg::FLAGS_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic handler, record and log
  // ----------------------------------------------------------------
  logic [7:0] rec_b0;
  logic [7:0] rec_b1;
  logic [7:0] rec_b3;

  assign rec_b1 = {3'b000, 1'b1, MODULE_CLASS};

  always_ff @(posedge clock) begin
    if (rst) begin
      rec_b0 <= tech_irq_pkg::DIAG_BYTE_RESET;
      rec_b3 <= tech_irq_pkg::DIAG_BYTE_RESET;
    end else if (enter_in || lost_event) begin
      rec_b0 <= 8'h00;
      rec_b0[tech_irq_pkg::CHANNEL_ERROR_BIT] <= 1'b1;
      rec_b3 <= 8'h00;
      rec_b3[tech_irq_pkg::LOST_EVENT_BIT] <= 1'b1;
    end else if (enter_out) begin
      rec_b0 <= 8'h00;
      rec_b0[tech_irq_pkg::CHANNEL_ERROR_BIT] <=
        |(diag_chan & ~(NE'(1) << cur_id));
      rec_b3 <= tech_irq_pkg::FIX_ZERO_BYTE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      diag_irq_handler <= 1'b0;
      diag_outgoing    <= 1'b0;
      diag_record      <= '0;
    end else if (enter_in || enter_out) begin
      diag_irq_handler <= 1'b1;
      diag_outgoing    <= enter_out;
      diag_record <= {enter_out ? tech_irq_pkg::FIX_ZERO_BYTE :
                      8'h40, tech_irq_pkg::FIX_ZERO_BYTE, rec_b1,
                      enter_out ?
                      {4'h0, |(diag_chan & ~(NE'(1) << cur_id)), 3'b000}
                      : 8'h08};
    end else if (diag_done) begin
      diag_irq_handler <= 1'b0;
      diag_outgoing    <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      log_strobe <= 1'b0;
      log_entry  <= '0;
    end else begin
      log_strobe <= enter_in || enter_out;
      log_entry  <= {enter_out, 2'b00,
                     enter_in && diag_q.pop ? diag_q.pop_data :
                     ev_recur ? ev_id : cur_id, MODULE_ADDR};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      system_fault_indicator <= 1'b0;
    end else begin
      system_fault_indicator <= |diag_chan;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        tech_irq_pkg::OFS_DIAG_ERROR_SUMMARY: reg_rdata <= rec_b0;
        tech_irq_pkg::OFS_DIAG_MODULE_CLASS:  reg_rdata <= rec_b1;
        tech_irq_pkg::OFS_DIAG_RESERVED_BYTE:
          reg_rdata <= tech_irq_pkg::FIX_ZERO_BYTE;
        tech_irq_pkg::OFS_DIAG_LOST_EVENT:    reg_rdata <= rec_b3;
        tech_irq_pkg::OFS_EDGE_FLAGS_LOW:     reg_rdata <= proc_flags[7:0];
        tech_irq_pkg::OFS_EDGE_FLAGS_HIGH:    reg_rdata <= proc_flags[15:8];
        tech_irq_pkg::OFS_MEASURE_DONE_CH01:  reg_rdata <= proc_flags[23:16];
        tech_irq_pkg::OFS_MEASURE_DONE_CH23:  reg_rdata <= proc_flags[31:24];
        default:                              reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_pwm_no_proc: assert property (
    tech_mode == tech_irq_pkg::MODE_PWM |-> ##1 !proc_q.push)
    else $error("process event queued in pwm mode");
  chk_diag_gate: assert property (
    !diag_en |-> !enter_in && !enter_out)
    else $error("diagnostic raised while disabled");
  chk_recur_preempt: assert property (
    ev_recur && diag_en |=> diag_irq_handler && !process_irq_handler)
    else $error("recurrence did not pre-empt");
  chk_resume_proc: assert property (
    state == tech_irq_pkg::ST_DIAG_IN && diag_done && susp_valid &&
    diag_q.empty |=> ##1 process_irq_handler)
    else $error("interrupted process not resumed");
  chk_diag_first: assert property (
    state == tech_irq_pkg::ST_IDLE && !diag_q.empty |=> 
    state == tech_irq_pkg::ST_DIAG_IN)
    else $error("queued diagnostic not served first");
  chk_chan_drop: assert property (
    ev_valid && diag_chan[ev_id] |-> !proc_q.push && !diag_q.push)
    else $error("event of channel in diagnosis stored");
  chk_out_follow: assert property (
    enter_out |=> diag_irq_handler && diag_outgoing)
    else $error("outgoing diagnostic missing");
  chk_fault_led: assert property (
    (|diag_chan) |=> system_fault_indicator)
    else $error("fault indicator off during diagnosis");
  chk_log_entry: assert property (
    $rose(diag_irq_handler) |-> log_strobe)
    else $error("diagnostic call not logged");
  chk_flags_hold: assert property (
    process_irq_handler && !proc_done && !ev_recur |=>
    $stable(proc_flags))
    else $error("process flags changed in service");

  cov_recur: cover property (ev_recur && diag_en);
  cov_outgoing: cover property (enter_out);
  cov_overflow: cover property (ev_to_proc && proc_q.full);

endmodule

// file: test/host_handler_model.sv
// Purpose: Host handler model answering process and diagnostic requests.
// Assumes: A request stays high until the edge after its done pulse.
// Notes:   Done comes delay cycles after entry; a pre-emption restarts it.
`timescale 1ns/1ps
module host_handler_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  delay,
  input  wire logic        process_irq_handler,
  input  wire logic [31:0] proc_flags,
  input  wire logic        diag_irq_handler,
  input  wire logic [31:0] diag_record,
  output logic             proc_done,
  output logic             diag_done,
  output logic [7:0]       proc_count,
  output logic [7:0]       diag_count,
  output logic [31:0]      last_flags,
  output logic [31:0]      last_record
);
  logic [8:0] proc_wait;
  logic [8:0] diag_wait;

  // ----------------------------------------------------------------
  // Handlers
  // ----------------------------------------------------------------
  // The wait saturates past delay, so each entry sees one done pulse only.
  always_ff @(posedge clock) begin
    proc_done <= !rst && process_irq_handler && proc_wait == {1'b0, delay};
    if (rst || !process_irq_handler) proc_wait <= 9'h000;
    else if (proc_wait <= {1'b0, delay}) proc_wait <= proc_wait + 9'h001;
    if (rst) proc_count <= 8'h00;
    else if (process_irq_handler && proc_wait == 9'h000) begin
      proc_count <= proc_count + 8'h01;
      last_flags <= proc_flags;
    end
  end

  // The record is taken on entry, before the handler is left.
  always_ff @(posedge clock) begin
    diag_done <= !rst && diag_irq_handler && diag_wait == {1'b0, delay};
    if (rst || !diag_irq_handler) diag_wait <= 9'h000;
    else if (diag_wait <= {1'b0, delay}) diag_wait <= diag_wait + 9'h001;
    if (rst) diag_count <= 8'h00;
    else if (diag_irq_handler && diag_wait == 9'h000) begin
      diag_count <= diag_count + 8'h01;
      last_record <= diag_record;
    end
  end
endmodule

// file: test/tb_tech_irq_diag.sv
// Purpose: Self-checking bench of the technology interrupt logic.
// Assumes: The host model answers every request after delay cycles.
// Notes:   Event ids 0..15 are edges, 16..19 measurement channels.
`timescale 1ns/1ps
module tb_tech_irq_diag;
  logic        clock = 1'b0, rst = 1'b1;
  logic [1:0]  tech_mode = tech_irq_pkg::MODE_FREQ;
  logic        diag_proc_setting = 1'b1, counter_out_en = 1'b1;
  logic        diag_global_en = 1'b1, proc_done, diag_done;
  logic [15:0] input_edge = 16'h0000, log_entry;
  logic [3:0]  measure_done = 4'h0, reg_addr = 4'h0;
  logic [7:0]  delay = 8'h06, reg_rdata, proc_count, diag_count;
  logic        process_irq_handler, diag_irq_handler, diag_outgoing;
  logic        system_fault_indicator, log_strobe;
  logic [31:0] proc_flags, diag_record, last_flags, last_record;
  int          fail_count = 0, checks_done = 0;

  always #5 clock = ~clock;

  tech_irq_diag tech_irq_diag_inst (.clock, .rst, .tech_mode,
    .diag_proc_setting, .counter_out_en, .diag_global_en, .input_edge,
    .measure_done, .proc_done, .diag_done, .reg_addr, .process_irq_handler,
    .proc_flags, .diag_irq_handler, .diag_outgoing, .diag_record,
    .system_fault_indicator, .log_strobe, .log_entry, .reg_rdata);
  host_handler_model host_handler_model_inst (.clock, .rst, .delay,
    .process_irq_handler, .proc_flags, .diag_irq_handler, .diag_record,
    .proc_done, .diag_done, .proc_count, .diag_count, .last_flags,
    .last_record);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic pick(input int w);
    return w == 0 ? process_irq_handler :
           w == 1 ? diag_irq_handler : system_fault_indicator;
  endfunction

  task automatic wait_for(input int w, input logic level);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (n < 300 && pick(w) !== level);
    check({31'h0, pick(w)}, {31'h0, level});
  endtask

  task automatic fire(input int id);
    @(posedge clock);
    if (id < 16) input_edge <= 16'h0001 << id;
    else measure_done <= 4'h1 << (id - 16);
    @(posedge clock);
    input_edge <= 16'h0000;
    measure_done <= 4'h0;
  endtask

  task automatic read_check(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    repeat (2) @(posedge clock);
    #1 check({24'h0, reg_rdata}, {24'h0, exp});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_flags();
    int b;
    for (int id = 0; id < 20; id++) begin
      b = id < 16 ? id : 16 + (id - 16) * 4;
      fire(id);
      wait_for(0, 1'b1);
      check(proc_flags, 32'h1 << b);
      read_check(4'h8 + 4'(b / 8), 8'h01 << (b % 8));
      wait_for(0, 1'b0);
      check(proc_flags, 32'h0);
    end
    $display("test flags done");
  endtask

  task automatic test_gating();
    logic [7:0] pc;
    pc = proc_count;
    for (int c = 0; c < 3; c++) begin
      @(posedge clock);
      tech_mode <= c == 0 ? tech_irq_pkg::MODE_PWM : tech_irq_pkg::MODE_FREQ;
      counter_out_en <= c != 1;
      diag_proc_setting <= c != 2;
      fire(2);
      fire(2);
      repeat (10) @(posedge clock);
      #1 check({24'h0, proc_count}, {24'h0, pc});
      check({31'h0, diag_irq_handler}, 32'h0);
    end
    @(posedge clock);
    tech_mode <= tech_irq_pkg::MODE_FREQ;
    counter_out_en <= 1'b1;
    diag_proc_setting <= 1'b1;
    $display("test gating done");
  endtask

  task automatic test_recur();
    logic [7:0] pc, dc;
    pc = proc_count;
    dc = diag_count;
    fire(3);
    wait_for(0, 1'b1);
    fire(3);
    wait_for(1, 1'b1);
    check({31'h0, process_irq_handler}, 32'h0);
    check({15'h0, log_strobe, log_entry}, 32'h0001_0310);
    check(diag_record, 32'h4000_1F08);
    @(posedge clock);
    #1 check({31'h0, system_fault_indicator}, 32'h1);
    fire(5);
    fire(3);
    wait_for(0, 1'b1);
    check(proc_flags, 32'h0000_0008);
    wait_for(1, 1'b1);
    check({31'h0, diag_outgoing}, 32'h1);
    check({15'h0, log_strobe, log_entry}, 32'h0001_8310);
    check(diag_record, 32'h0000_1F00);
    wait_for(2, 1'b0);
    repeat (100) @(posedge clock);
    #1 check({24'h0, proc_count}, {24'h0, pc + 8'h03});
    check({24'h0, diag_count}, {24'h0, dc + 8'h02});
    check(last_flags, 32'h0000_0020);
    check(last_record, 32'h0000_1F00);
    $display("test recurrence done");
  endtask

  task automatic test_disabled();
    logic [7:0] dc;
    @(posedge clock);
    diag_global_en <= 1'b0;
    dc = diag_count;
    fire(7);
    wait_for(0, 1'b1);
    fire(7);
    wait_for(0, 1'b0);
    check({24'h0, diag_count}, {24'h0, dc});
    read_check(4'h0, 8'h08);
    read_check(4'h3, 8'h40);
    read_check(4'h2, 8'h00);
    read_check(4'h1, 8'h1F);
    read_check(4'h4, 8'h00);
    $display("test disabled done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    test_flags();
    test_gating();
    delay <= 8'h1E;
    test_recur();
    test_disabled();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    report_and_stop();
  end
endmodule
